//--- hw/adc_port_pkg.sv
/*
 * Shared constants and types of the serial command port of the 10-bit converter.
 * Assumes the serial clock is sampled as an ordinary synchronous input.
 */
package adc_port_pkg;

   localparam int RESULT_W = 10;
   localparam int SEL_W = 3;
   localparam int CNT_W = 6;
   localparam int CODE_W = 11;

   // clock numbers counted from the start bit (start bit clock is 0)
   localparam logic [CNT_W-1:0] ACQ_START_CLK = 6'h04;
   localparam logic [CNT_W-1:0] ACQ_END_CLK = 6'h05;
   localparam logic [CNT_W-1:0] NULL_CLK = 6'h06;
   localparam logic [CNT_W-1:0] MSB_CLK = 6'h07;
   localparam logic [CNT_W-1:0] LSB_CLK = 6'h10;
   localparam logic [CNT_W-1:0] REVERSE_END_CLK = 6'h19;
   localparam logic [CNT_W-1:0] CNT_MAX = 6'h3F;
   localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;

   localparam logic [RESULT_W-1:0] CODE_ZERO = 10'h000;
   localparam logic [RESULT_W-1:0] CODE_FULL = 10'h3FF;
   localparam logic [SEL_W-1:0] SEL_ZERO = 3'h0;

   typedef enum logic [4:0] {
      LOCKOUT = 5'h01,
      STANDBY = 5'h02,
      WAIT_START = 5'h04,
      COMMAND = 5'h08,
      OUTPUT = 5'h10
   } port_state_type;

endpackage

//--- hw/conv_if.sv
/*
 * Carrier between the port controller, the channel decoder and the output shifter.
 * Assumes all three sit on the one system clock.
 */
`timescale 1ns/10ps
`default_nettype none

interface conv_if;
   logic diff_mode;
   logic [adc_port_pkg::SEL_W-1:0] chan_sel;
   logic [adc_port_pkg::SEL_W-1:0] pos_input;
   logic [adc_port_pkg::SEL_W-1:0] neg_input;
   logic [adc_port_pkg::RESULT_W-1:0] result;
   logic [adc_port_pkg::CNT_W-1:0] clk_idx;
   logic out_bit;

   modport ctrl (output diff_mode, output chan_sel, output result, output clk_idx,
                 input pos_input, input neg_input, input out_bit);
   modport decode (input diff_mode, input chan_sel, output pos_input, output neg_input);
   modport shift (input result, input clk_idx, output out_bit);
endinterface

`default_nettype wire

//--- hw/chan_decode.sv
/*
 * Turns the mode bit and three select bits into positive and negative input numbers.
 * Assumes the select bits are stable while the controller samples the outputs.
 */
`timescale 1ns/10ps
`default_nettype none

module chan_decode #(
   parameter bit FOUR_INPUTS = 1'b0
) (
   conv_if.decode bus
);

   logic [adc_port_pkg::SEL_W-1:0] sel;

   always_comb begin
      sel = bus.chan_sel;
      if (FOUR_INPUTS) begin
         sel[2] = 1'b0;
      end
      if (bus.diff_mode) begin
         bus.pos_input = {sel[2:1], sel[0]};
         bus.neg_input = {sel[2:1], ~sel[0]};
      end else begin
         bus.pos_input = sel;
         bus.neg_input = adc_port_pkg::SEL_ZERO;
      end
   end

endmodule // chan_decode

`default_nettype wire

//--- hw/result_shifter.sv
/*
 * Picks the serial output bit for a given clock number after the start bit.
 * Assumes the result is frozen once acquisition has ended.
 */
`timescale 1ns/10ps
`default_nettype none

module result_shifter (
   conv_if.shift bus
);

   logic [adc_port_pkg::CNT_W-1:0] ofs;

   always_comb begin
      ofs = '0;
      bus.out_bit = 1'b0;
      if (bus.clk_idx >= adc_port_pkg::MSB_CLK && bus.clk_idx <= adc_port_pkg::LSB_CLK) begin
         ofs = adc_port_pkg::LSB_CLK - bus.clk_idx;
         bus.out_bit = bus.result[ofs[3:0]];
      end else if (bus.clk_idx > adc_port_pkg::LSB_CLK && bus.clk_idx <= adc_port_pkg::REVERSE_END_CLK) begin
         // lsb is shared with the msb-first copy, so the reverse copy resumes at bit 1
         ofs = bus.clk_idx - adc_port_pkg::LSB_CLK;
         bus.out_bit = bus.result[ofs[3:0]];
      end
   end

endmodule // result_shifter

`default_nettype wire

//--- hw/sar_adc_serial_command_port.sv
/*
 * Serial command and result port of a 10-bit successive-approximation converter.
 * Assumes serial clock, chip select and data in are synchronous to sys_clk_i and
 * that each serial clock phase spans at least two system clocks.
 */
// Operation
// - a transaction begins only when the select input is low
// - select high aborts conversion and enters standby
// - select low at power-up: ignore traffic until raised and lowered
// - first rising clock with data in high is the start bit
// - leading zeros before the start bit are ignored
// - bit after start: 1 single-ended, 0 pseudo-differential
// - three select bits follow, most significant first, and are latched
// - single-ended converts the input numbered by the select bits
// - differential: upper bits pick pair, last bit picks positive input
// - four-input variant ignores the top select bit
// - acquisition starts on the fourth rising edge after start
// - acquisition ends on the falling edge of the fifth clock
// - one extra clock ends acquisition; data in ignored then
// - next falling edge drives a low null bit
// - next ten clocks give the result msb first
// - output changes only on falling serial clock edges
// - further clocks repeat the result lsb first
// - afterwards zeros for as long as select stays low
// - differential result saturates to 000h and 3FFh
`timescale 1ns/10ps
`default_nettype none

module sar_adc_serial_command_port #(
   parameter bit FOUR_INPUTS = 1'b0
) (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic serial_clk_i,
   input wire logic select_and_sleep_n_i,
   input wire logic serial_data_i,
   input wire logic signed [adc_port_pkg::CODE_W-1:0] sample_code_i,
   output logic serial_data_o,
   output logic serial_data_oe_o,
   output logic standby_o,
   output logic acquire_o,
   output logic input_mode_bit_o,
   output logic [adc_port_pkg::SEL_W-1:0] pos_input_o,
   output logic [adc_port_pkg::SEL_W-1:0] neg_input_o,
   output logic [adc_port_pkg::RESULT_W-1:0] result_o
);

   conv_if link ();

   adc_port_pkg::port_state_type state_reg;
   logic sclk_prev_reg;
   logic [adc_port_pkg::CNT_W-1:0] clk_cnt_reg;
   logic [adc_port_pkg::SEL_W-1:0] chan_sel_reg;
   logic mode_reg;
   logic [adc_port_pkg::RESULT_W-1:0] result_reg;
   logic rise;
   logic fall;
   logic select_n;

   // the analog side may hand in a code beyond the range; the port clamps it
   function automatic logic [adc_port_pkg::RESULT_W-1:0] saturate(
      input logic signed [adc_port_pkg::CODE_W-1:0] code
   );
      logic [adc_port_pkg::RESULT_W-1:0] r;
      r = code[adc_port_pkg::RESULT_W-1:0];
      if (code[adc_port_pkg::CODE_W-1]) begin
         r = adc_port_pkg::CODE_ZERO;
      end else if (code > $signed({1'b0, adc_port_pkg::CODE_FULL})) begin
         r = adc_port_pkg::CODE_FULL;
      end
      return r;
   endfunction

   assign rise = serial_clk_i & ~sclk_prev_reg;
   assign fall = ~serial_clk_i & sclk_prev_reg;
   assign select_n = select_and_sleep_n_i;

   assign link.diff_mode = ~mode_reg;
   assign link.chan_sel = chan_sel_reg;
   assign link.result = result_reg;
   assign link.clk_idx = clk_cnt_reg;

   chan_decode #(
      .FOUR_INPUTS(FOUR_INPUTS)
   ) u_decode (
      .bus(link)
   );

   result_shifter u_shift (
      .bus(link)
   );

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         sclk_prev_reg <= 1'b0;
      end else begin
         sclk_prev_reg <= serial_clk_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         state_reg <= adc_port_pkg::LOCKOUT;
      end else if (select_n) begin
         state_reg <= adc_port_pkg::STANDBY;
      end else begin
         case (state_reg)
            adc_port_pkg::LOCKOUT: begin
               state_reg <= adc_port_pkg::LOCKOUT;
            end
            adc_port_pkg::STANDBY: begin
               state_reg <= adc_port_pkg::WAIT_START;
            end
            adc_port_pkg::WAIT_START: begin
               if (rise && serial_data_i) begin
                  state_reg <= adc_port_pkg::COMMAND;
               end
            end
            adc_port_pkg::COMMAND: begin
               if (fall && clk_cnt_reg == adc_port_pkg::ACQ_END_CLK) begin
                  state_reg <= adc_port_pkg::OUTPUT;
               end
            end
            adc_port_pkg::OUTPUT: begin
               state_reg <= adc_port_pkg::OUTPUT;
            end
            default: begin
               state_reg <= adc_port_pkg::STANDBY;
            end
         endcase
      end
   end

   // clock number since the start bit, held at its top value
   always_ff @(posedge sys_clk_i) begin
      if (reset_i || select_n || state_reg == adc_port_pkg::WAIT_START) begin
         clk_cnt_reg <= '0;
      end else if (rise && clk_cnt_reg != adc_port_pkg::CNT_MAX &&
                   (state_reg == adc_port_pkg::COMMAND || state_reg == adc_port_pkg::OUTPUT)) begin
         clk_cnt_reg <= clk_cnt_reg + adc_port_pkg::CNT_ONE;
      end
   end

   // command bits arrive on rising edges 1 to 4 after the start bit
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         mode_reg <= 1'b1;
         chan_sel_reg <= adc_port_pkg::SEL_ZERO;
      end else if (state_reg == adc_port_pkg::COMMAND && rise &&
                   clk_cnt_reg < adc_port_pkg::ACQ_START_CLK) begin
         if (clk_cnt_reg == '0) begin
            mode_reg <= serial_data_i;
         end else begin
            chan_sel_reg <= {chan_sel_reg[1:0], serial_data_i};
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         input_mode_bit_o <= 1'b1;
         pos_input_o <= adc_port_pkg::SEL_ZERO;
         neg_input_o <= adc_port_pkg::SEL_ZERO;
      end else begin
         input_mode_bit_o <= mode_reg;
         pos_input_o <= link.pos_input;
         neg_input_o <= link.neg_input;
      end
   end

   // sample window: rising edge of clock 4 to falling edge of clock 5
   always_ff @(posedge sys_clk_i) begin
      if (reset_i || select_n) begin
         acquire_o <= 1'b0;
      end else if (state_reg == adc_port_pkg::COMMAND && rise &&
                   clk_cnt_reg == adc_port_pkg::ACQ_START_CLK - adc_port_pkg::CNT_ONE) begin
         acquire_o <= 1'b1;
      end else if (fall && clk_cnt_reg == adc_port_pkg::ACQ_END_CLK) begin
         acquire_o <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         result_reg <= adc_port_pkg::CODE_ZERO;
      end else if (state_reg == adc_port_pkg::COMMAND && fall &&
                   clk_cnt_reg == adc_port_pkg::ACQ_END_CLK) begin
         result_reg <= saturate(sample_code_i);
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         result_o <= adc_port_pkg::CODE_ZERO;
      end else begin
         result_o <= result_reg;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i || select_n) begin
         serial_data_oe_o <= 1'b0;
         serial_data_o <= 1'b0;
      end else if (state_reg == adc_port_pkg::OUTPUT && fall &&
                   clk_cnt_reg >= adc_port_pkg::NULL_CLK) begin
         serial_data_oe_o <= 1'b1;
         serial_data_o <= link.out_bit;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         standby_o <= 1'b1;
      end else begin
         standby_o <= state_reg == adc_port_pkg::STANDBY || state_reg == adc_port_pkg::LOCKOUT;
      end
   end

endmodule // sar_adc_serial_command_port

`default_nettype wire

//--- test/adc_port_chk.sv
/* Assertions on the serial converter port, seeing only its top-level ports.
   Assumes one system clock and a synchronous active-high reset. */
`timescale 1ns/10ps
`default_nettype none
module adc_port_chk (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic serial_clk_i,
   input wire logic select_and_sleep_n_i,
   input wire logic serial_data_o,
   input wire logic serial_data_oe_o,
   input wire logic standby_o,
   input wire logic acquire_o,
   input wire logic [adc_port_pkg::RESULT_W-1:0] result_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   standby_entry_a: assert property (select_and_sleep_n_i [*3] |-> standby_o)
      else $error("standby not entered with select high");
   oe_release_a: assert property (select_and_sleep_n_i |=> !serial_data_oe_o)
      else $error("output driven with select high");
   acq_abort_a: assert property (select_and_sleep_n_i |=> !acquire_o)
      else $error("acquisition kept with select high");
   data_on_fall_a: assert property ($changed(serial_data_o) && serial_data_oe_o && $past(serial_data_oe_o)
      |-> $past(serial_clk_i, 2) && !$past(serial_clk_i)) else $error("output changed off a falling clock");
   null_bit_a: assert property ($rose(serial_data_oe_o)
      |-> !serial_data_o && $past(serial_clk_i, 2) && !$past(serial_clk_i)) else $error("bad null bit");
   acq_start_a: assert property ($rose(acquire_o) |-> $past(serial_clk_i) && !$past(serial_clk_i, 2))
      else $error("acquisition began off a rising clock");
   acq_end_a: assert property ($fell(acquire_o) && !$past(select_and_sleep_n_i)
      |-> $past(serial_clk_i, 2) && !$past(serial_clk_i)) else $error("acquisition ended off a falling clock");
   result_hold_a: assert property (serial_data_oe_o |-> $stable(result_o))
      else $error("result moved while shifting out");
   cover property ($rose(serial_data_oe_o));
   cover property ($fell(acquire_o));
   cover property ($rose(standby_o));
endmodule // adc_port_chk
bind sar_adc_serial_command_port adc_port_chk adc_port_chk_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
   .serial_clk_i(serial_clk_i), .select_and_sleep_n_i(select_and_sleep_n_i), .serial_data_o(serial_data_o),
   .serial_data_oe_o(serial_data_oe_o), .standby_o(standby_o), .acquire_o(acquire_o), .result_o(result_o));
`default_nettype wire

//--- test/spi_master_model.sv
/* Behavioural serial master that sends one command per frame.
   Assumes it is stepped on falling system clock edges; its clock idles low or high, chosen per frame. */
`timescale 1ns/10ps
`default_nettype none
module spi_master_model (
   input wire logic sys_clk_i,
   output logic serial_clk_o,
   output logic select_and_sleep_n_o,
   output logic serial_data_o
);
   // select starts low so the power-up lockout is exercised
   initial begin
      serial_clk_o = 1'h0;
      select_and_sleep_n_o = 1'h0;
      serial_data_o = 1'h0;
   end
   task automatic wait_sys(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask
   task automatic frame(input logic mode, input logic [2:0] sel, input int zeros, input int nclk,
                        input logic idle_high);
      int j;
      // park the clock at its idle level before select is driven low
      serial_clk_o = idle_high;
      wait_sys(1);
      select_and_sleep_n_o = 1'h0;
      wait_sys(2);
      for (int i = 0; i < zeros + nclk; i++) begin
         j = i - zeros;
         if (idle_high) serial_clk_o = 1'h0;
         if (j < 0) serial_data_o = 1'h0;
         else if (j == 0) serial_data_o = 1'h1;
         else if (j == 1) serial_data_o = mode;
         else if (j < 5) serial_data_o = sel[4 - j];
         else serial_data_o = ~serial_data_o;
         // three system clocks a phase keeps the result well inside the hold time
         wait_sys(3);
         serial_clk_o = 1'h1;
         wait_sys(3);
         if (!idle_high) serial_clk_o = 1'h0;
      end
   endtask
   task automatic finish();
      wait_sys(2);
      select_and_sleep_n_o = 1'h1;
      wait_sys(4);
   endtask
endmodule // spi_master_model
`default_nettype wire

//--- test/sar_adc_serial_command_port_bench.sv
/* Self-checking bench of the converter serial port with a behavioural master.
   Assumes the design packages are compiled first; the expected bit stream waits in a queue. */
`timescale 1ns/10ps
`default_nettype none
module sar_adc_serial_command_port_bench;
   logic sys_clk_i = 1'h0;
   logic reset_i = 1'h1;
   logic signed [adc_port_pkg::CODE_W-1:0] code = '0;
   wire serial_clk;
   wire sel_n;
   wire mosi;
   logic miso, oe, standby, acquire, mode_o;
   logic [2:0] pos, neg, pos4;
   logic [9:0] result;
   logic [9:0] exp_q[$];
   int n_fail = 0;
   int n_checks = 0;
   logic [31:0] seed = 32'h99F9BAB0;
   logic prev_clk = 1'h0;
   always #25 sys_clk_i = ~sys_clk_i;
   spi_master_model spi_master_model_i (.sys_clk_i(sys_clk_i), .serial_clk_o(serial_clk),
      .select_and_sleep_n_o(sel_n), .serial_data_o(mosi));
   sar_adc_serial_command_port sar_adc_serial_command_port_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
      .serial_clk_i(serial_clk), .select_and_sleep_n_i(sel_n), .serial_data_i(mosi), .sample_code_i(code),
      .serial_data_o(miso), .serial_data_oe_o(oe), .standby_o(standby), .acquire_o(acquire),
      .input_mode_bit_o(mode_o), .pos_input_o(pos), .neg_input_o(neg), .result_o(result));
   // second name needed: the four-input variant shares every input
   sar_adc_serial_command_port #(.FOUR_INPUTS(1'h1)) sar_adc_serial_command_port_four_i (.sys_clk_i(sys_clk_i),
      .reset_i(reset_i), .serial_clk_i(serial_clk), .select_and_sleep_n_i(sel_n), .serial_data_i(mosi),
      .sample_code_i(code), .serial_data_o(), .serial_data_oe_o(), .standby_o(), .acquire_o(),
      .input_mode_bit_o(), .pos_input_o(pos4), .neg_input_o(), .result_o());
   function automatic logic [31:0] next_rand(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction
   task automatic check(input logic [9:0] got, input logic [9:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask
   task automatic close_out();
      if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // serial clock k counted from the start bit; rise k shows what fall k-1 drove
   task automatic expect_bits(input logic [9:0] r, input int nclk);
      for (int k = 7; k < nclk; k++) begin
         if (k == 7) exp_q.push_back(10'h000);
         else if (k < 18) exp_q.push_back(10'(r[17 - k]));
         else if (k < 27) exp_q.push_back(10'(r[k - 17]));
         else exp_q.push_back(10'h000);
      end
   endtask
   // empty queue yields a value no single bit can match
   always @(posedge sys_clk_i) begin
      prev_clk <= serial_clk;
      if (serial_clk === 1'h1 && prev_clk === 1'h0 && oe === 1'h1)
         check(10'(miso), exp_q.size() > 0 ? exp_q.pop_front() : 10'h2AA);
   end
   initial begin
      repeat (20000) @(posedge sys_clk_i);
      n_fail++;
      close_out();
   end
   initial begin
      logic [2:0] sel;
      logic [9:0] r;
      repeat (6) @(negedge sys_clk_i);
      reset_i = 1'h0;
      spi_master_model_i.frame(1'h1, 3'h5, 0, 14, 1'h0);
      check(10'(oe), 10'h000);
      spi_master_model_i.finish();
      check(10'(standby), 10'h001);
      for (int m = 0; m < 16; m++) begin
         seed = next_rand(seed);
         code = seed[10:0];
         sel = 3'(m);
         r = (code < 0) ? 10'h000 : code[9:0];
         expect_bits(r, 30);
         spi_master_model_i.frame(m[3], sel, int'(seed[13:12]), 30, seed[14]);
         check(10'(standby), 10'h000);
         check(10'(mode_o), 10'(m[3]));
         check(10'(pos), 10'(sel));
         check(10'(neg), m[3] ? 10'h000 : 10'({sel[2:1], ~sel[0]}));
         check(10'(pos4), 10'({1'h0, sel[1:0]}));
         check(result, r);
         spi_master_model_i.finish();
         check(10'(exp_q.size()), 10'h000);
      end
      expect_bits(r, 12);
      spi_master_model_i.frame(1'h1, 3'h0, 1, 12, 1'h1);
      spi_master_model_i.finish();
      check(10'(oe), 10'h000);
      check(10'(standby), 10'h001);
      check(10'(exp_q.size()), 10'h000);
      close_out();
   end
endmodule // sar_adc_serial_command_port_bench
`default_nettype wire
